// [core/pndb_pkg.sv]
package pndb_pkg;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int NUM_GROUPS = 4;
    localparam int GROUP_W = 4;
    localparam int SEL_W = 2;
    localparam int PAT_W = 16;
    localparam int BYTE_W = 8;
    localparam int NIB_W = 4;

    // Byte addresses of the register map
    localparam logic [ADDR_W-1:0] ADDR_TRIG_SEL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_NON_OVERLAP = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_ENABLE = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_OUT_PAT = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_NEXT_HIGH = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_NEXT_HIGH_LN = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_NEXT_LOW = 8'h18;
    localparam logic [ADDR_W-1:0] ADDR_NEXT_LOW_LN = 8'h1C;

    // Reset values and the read value of an unused nibble
    localparam logic [BYTE_W-1:0] TRIG_SEL_RST = 8'hFF;
    localparam logic [NIB_W-1:0] NON_OVERLAP_RST = 4'h0;
    localparam logic [PAT_W-1:0] ENABLE_RST = 16'h0000;
    localparam logic [PAT_W-1:0] OUT_PAT_RST = 16'h0000;
    localparam logic [BYTE_W-1:0] NEXT_RST = 8'h00;
    localparam logic [NIB_W-1:0] RESERVED_ONES = 4'hF;

    // Field positions: trigger-select groups, pattern high byte, upper nibble
    localparam int SEL_G0_LSB = 0;
    localparam int SEL_G1_LSB = 2;
    localparam int SEL_G2_LSB = 4;
    localparam int SEL_G3_LSB = 6;
    localparam int HIGH_LSB = 8;
    localparam int UPPER_LSB = 4;
endpackage

// [core/pndb_trig_sel.sv]
`timescale 1ns/100ps
`default_nettype none
module pndb_trig_sel (
    input wire logic [pndb_pkg::SEL_W-1:0] sel,
    input wire logic non_overlap,
    input wire logic [pndb_pkg::NUM_GROUPS-1:0] compare_match_a,
    input wire logic [pndb_pkg::NUM_GROUPS-1:0] compare_match_b,
    output logic trig
);
    import pndb_pkg::*;

    always_comb begin
        // Match B only counts in non-overlapping operation
        trig = compare_match_a[sel] | (non_overlap & compare_match_b[sel]); // R13 R14
    end
endmodule
`default_nettype wire

// [core/pndb_core.sv]
// Operation
// R1: Two 8-bit next-pattern registers, high and low, hold data for next trigger.
// R2: High register holds pattern bits 15..8, read/write, zero at reset.
// R3: Low register holds pattern bits 7..0, read/write, zero at reset.
// R4: Group trigger copies high next bits into matching output pattern bits.
// R5: Group trigger copies low next bits into matching output pattern bits.
// R6: Address mapping depends on whether paired groups share a trigger.
// R7: Groups 2 and 3 sharing a trigger: all high bits at one address.
// R8: Groups 2 and 3 split: bits 15..12 and 11..8 at separate addresses.
// R9: Groups 0 and 1 sharing a trigger: all low bits at one address.
// R10: Groups 0 and 1 split: bits 7..4 and 3..0 at separate addresses.
// R11: Unused nibble in split views reads all ones, writes ignored.
// R12: A bit transfers only when its enable is set; others keep value.
// R13: Two-bit select per group picks timer channel 0..3 compare match.
// R14: Normal mode triggers on match A; non-overlap on match A or B.
// R15: Mapping chosen by comparing pair select fields, updated on every write.
`timescale 1ns/100ps
`default_nettype none
module pndb_core (
    input wire logic clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pndb_pkg::ADDR_W-1:0] paddr,
    input wire logic [pndb_pkg::DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [pndb_pkg::NUM_GROUPS-1:0] compare_match_a,
    input wire logic [pndb_pkg::NUM_GROUPS-1:0] compare_match_b,
    output logic [pndb_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [pndb_pkg::PAT_W-1:0] pattern_out
);
    import pndb_pkg::*;

    logic [BYTE_W-1:0] trig_sel_r, trig_sel_nxt;
    logic [NIB_W-1:0] non_overlap_r, non_overlap_nxt;
    logic [PAT_W-1:0] enable_r, enable_nxt;
    logic [BYTE_W-1:0] next_high_r, next_high_nxt;
    logic [BYTE_W-1:0] next_low_r, next_low_nxt;
    logic [PAT_W-1:0] out_pat_r, out_pat_nxt;
    logic [DATA_W-1:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt;
    logic pslverr_r, pslverr_nxt;
    logic [NUM_GROUPS-1:0] grp_trig;
    logic shared_high, shared_low;
    logic setup, wr;
    logic [BYTE_W-1:0] rd_byte;
    logic [PAT_W-1:0] rd_wide;
    logic rd_hit;
    logic [PAT_W-1:0] next_pat;

    // Nibble view: requested half in place, other half forced to ones
    function automatic logic [BYTE_W-1:0] nib_view(input logic [BYTE_W-1:0] d,
                                                   input logic upper);
        if (upper) begin
            nib_view = {d[BYTE_W-1:UPPER_LSB], RESERVED_ONES};
        end else begin
            nib_view = {RESERVED_ONES, d[NIB_W-1:0]};
        end
    endfunction

    function automatic logic same_trigger(input logic [BYTE_W-1:0] sel, input int lsb_a,
                                          input int lsb_b);
        same_trigger = (sel[lsb_a +: SEL_W] == sel[lsb_b +: SEL_W]);
    endfunction

    // Merge a write into a byte, in full or split nibble view
    function automatic logic [BYTE_W-1:0] merge_wr(input logic [BYTE_W-1:0] old,
                                                   input logic [BYTE_W-1:0] wd,
                                                   input logic shared, input logic lower_addr);
        if (shared) begin
            merge_wr = lower_addr ? old : wd;
        end else if (lower_addr) begin
            merge_wr = {old[BYTE_W-1:UPPER_LSB], wd[NIB_W-1:0]};
        end else begin
            merge_wr = {wd[BYTE_W-1:UPPER_LSB], old[NIB_W-1:0]};
        end
    endfunction

    for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_trig
        pndb_trig_sel u_trig_sel (
            .sel(trig_sel_r[g*SEL_W +: SEL_W]),
            .non_overlap(non_overlap_r[g]),
            .compare_match_a(compare_match_a),
            .compare_match_b(compare_match_b),
            .trig(grp_trig[g])
        );
    end

    always_comb begin
        // Recomputed from the live select register, so any write retargets the map
        shared_high = same_trigger(trig_sel_r, SEL_G2_LSB, SEL_G3_LSB); // R6 R15
        shared_low = same_trigger(trig_sel_r, SEL_G0_LSB, SEL_G1_LSB); // R6 R15
    end

    assign setup = psel & ~penable;
    assign wr = psel & penable & pready_r & pwrite;
    assign next_pat = {next_high_r, next_low_r};

    // Read decode, evaluated in the setup cycle
    always_comb begin
        rd_byte = '0;
        rd_wide = '0;
        rd_hit = 1'b1;
        case (paddr)
            ADDR_TRIG_SEL: rd_byte = trig_sel_r;
            ADDR_NON_OVERLAP: rd_byte = {{(BYTE_W-NIB_W){1'b0}}, non_overlap_r};
            ADDR_ENABLE: rd_wide = enable_r;
            ADDR_OUT_PAT: rd_wide = out_pat_r;
            ADDR_NEXT_HIGH: rd_byte = shared_high ? next_high_r : nib_view(next_high_r, 1'b1); // R7 R8 R11
            ADDR_NEXT_HIGH_LN: begin
                rd_hit = ~shared_high;
                rd_byte = shared_high ? '0 : nib_view(next_high_r, 1'b0); // R8 R11
            end
            ADDR_NEXT_LOW: rd_byte = shared_low ? next_low_r : nib_view(next_low_r, 1'b1); // R9 R10 R11
            ADDR_NEXT_LOW_LN: begin
                rd_hit = ~shared_low;
                rd_byte = shared_low ? '0 : nib_view(next_low_r, 1'b0); // R10 R11
            end
            default: rd_hit = 1'b0;
        endcase
    end

    // Bus slave: no wait states, answer registered during setup
    always_comb begin
        pready_nxt = setup;
        prdata_nxt = '0;
        pslverr_nxt = 1'b0;
        if (setup) begin
            pslverr_nxt = ~rd_hit;
            if (!pwrite) begin
                prdata_nxt = {{(DATA_W-PAT_W){1'b0}}, rd_wide | {{(PAT_W-BYTE_W){1'b0}}, rd_byte}};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            pready_r <= 1'b0;
            prdata_r <= '0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= pready_nxt;
            prdata_r <= prdata_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    // Register writes and pattern transfer
    always_comb begin
        trig_sel_nxt = trig_sel_r;
        non_overlap_nxt = non_overlap_r;
        enable_nxt = enable_r;
        next_high_nxt = next_high_r;
        next_low_nxt = next_low_r;
        out_pat_nxt = out_pat_r;
        for (int i = 0; i < PAT_W; i++) begin
            // Trigger loads old next data even if a write lands in the same cycle
            if (grp_trig[i / GROUP_W] && enable_r[i]) begin
                out_pat_nxt[i] = next_pat[i]; // R4 R5 R12
            end
        end
        if (wr && pstrb[0]) begin
            case (paddr)
                ADDR_TRIG_SEL: trig_sel_nxt = pwdata[BYTE_W-1:0]; // R13 R15
                ADDR_NON_OVERLAP: non_overlap_nxt = pwdata[NIB_W-1:0]; // R14
                ADDR_ENABLE: enable_nxt[BYTE_W-1:0] = pwdata[BYTE_W-1:0];
                ADDR_OUT_PAT: begin
                    // Only bits not under pulse output are software writable
                    for (int i = 0; i < BYTE_W; i++) begin
                        if (!enable_r[i]) begin
                            out_pat_nxt[i] = pwdata[i];
                        end
                    end
                end
                ADDR_NEXT_HIGH: next_high_nxt = merge_wr(next_high_r, pwdata[BYTE_W-1:0],
                                                         shared_high, 1'b0); // R7 R8 R11
                ADDR_NEXT_HIGH_LN: next_high_nxt = merge_wr(next_high_r, pwdata[BYTE_W-1:0],
                                                            shared_high, 1'b1); // R8 R11
                ADDR_NEXT_LOW: next_low_nxt = merge_wr(next_low_r, pwdata[BYTE_W-1:0],
                                                       shared_low, 1'b0); // R9 R10 R11
                ADDR_NEXT_LOW_LN: next_low_nxt = merge_wr(next_low_r, pwdata[BYTE_W-1:0],
                                                          shared_low, 1'b1); // R10 R11
                default: ;
            endcase
        end
        if (wr && pstrb[1]) begin
            if (paddr == ADDR_ENABLE) begin
                enable_nxt[PAT_W-1:HIGH_LSB] = pwdata[PAT_W-1:HIGH_LSB];
            end else if (paddr == ADDR_OUT_PAT) begin
                for (int i = HIGH_LSB; i < PAT_W; i++) begin
                    if (!enable_r[i]) begin
                        out_pat_nxt[i] = pwdata[i];
                    end
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            trig_sel_r <= TRIG_SEL_RST;
            non_overlap_r <= NON_OVERLAP_RST;
            enable_r <= ENABLE_RST;
            next_high_r <= NEXT_RST; // R1 R2
            next_low_r <= NEXT_RST; // R1 R3
            out_pat_r <= OUT_PAT_RST;
        end else begin
            trig_sel_r <= trig_sel_nxt;
            non_overlap_r <= non_overlap_nxt;
            enable_r <= enable_nxt;
            next_high_r <= next_high_nxt;
            next_low_r <= next_low_nxt;
            out_pat_r <= out_pat_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign pattern_out = out_pat_r;

    sequence s_wr(logic [ADDR_W-1:0] a);
        psel && penable && pready_r && pwrite && pstrb[0] && paddr == a;
    endsequence

    sequence s_rd_setup(logic [ADDR_W-1:0] a);
        psel && !penable && !pwrite && paddr == a;
    endsequence

    property p_reset_zero;
        @(posedge clk) !resetn |=> (next_high_r == 8'h00 && next_low_r == 8'h00);
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("next data not cleared by reset"); // R2

    property p_full_high_write;
        @(posedge clk) disable iff (!resetn)
        (s_wr(ADDR_NEXT_HIGH) and shared_high) |=> next_high_r == $past(pwdata[7:0]);
    endproperty
    a_full_high_write: assert property (p_full_high_write) else $error("full high write lost"); // R7

    property p_split_high_upper;
        @(posedge clk) disable iff (!resetn)
        (s_wr(ADDR_NEXT_HIGH) and !shared_high) |=>
            next_high_r == {$past(pwdata[7:4]), $past(next_high_r[3:0])};
    endproperty
    a_split_high_upper: assert property (p_split_high_upper) else $error("high nibble write"); // R8

    property p_full_low_write;
        @(posedge clk) disable iff (!resetn)
        (s_wr(ADDR_NEXT_LOW) and shared_low) |=> next_low_r == $past(pwdata[7:0]);
    endproperty
    a_full_low_write: assert property (p_full_low_write) else $error("full low write lost"); // R9

    property p_split_low_lower;
        @(posedge clk) disable iff (!resetn)
        (s_wr(ADDR_NEXT_LOW_LN) and !shared_low) |=>
            next_low_r == {$past(next_low_r[7:4]), $past(pwdata[3:0])};
    endproperty
    a_split_low_lower: assert property (p_split_low_lower) else $error("low nibble write"); // R10

    property p_reserved_ones;
        @(posedge clk) disable iff (!resetn)
        (s_rd_setup(ADDR_NEXT_HIGH_LN) and !shared_high) |=> pready_r && prdata_r[7:4] == 4'hF;
    endproperty
    a_reserved_ones: assert property (p_reserved_ones) else $error("reserved bits not ones"); // R11

    property p_high_transfer;
        @(posedge clk) disable iff (!resetn)
        grp_trig[3] |=> ((out_pat_r[15:12] ^ $past(next_high_r[7:4])) & $past(enable_r[15:12])) == 4'h0;
    endproperty
    a_high_transfer: assert property (p_high_transfer) else $error("group 3 transfer wrong"); // R4

    property p_low_transfer;
        @(posedge clk) disable iff (!resetn)
        grp_trig[0] |=> ((out_pat_r[3:0] ^ $past(next_low_r[3:0])) & $past(enable_r[3:0])) == 4'h0;
    endproperty
    a_low_transfer: assert property (p_low_transfer) else $error("group 0 transfer wrong"); // R5

    property p_disabled_hold;
        @(posedge clk) disable iff (!resetn)
        !(psel && penable && pwrite) |=> ((out_pat_r ^ $past(out_pat_r)) & ~$past(enable_r)) == 16'h0;
    endproperty
    a_disabled_hold: assert property (p_disabled_hold) else $error("disabled bit changed"); // R12

    property p_trigger_source;
        @(posedge clk) disable iff (!resetn)
        grp_trig[1] == (compare_match_a[trig_sel_r[3:2]]
                        || (non_overlap_r[1] && compare_match_b[trig_sel_r[3:2]]));
    endproperty
    a_trigger_source: assert property (p_trigger_source) else $error("group 1 trigger source"); // R13 R14

    property p_remap_on_write;
        @(posedge clk) disable iff (!resetn)
        (s_wr(ADDR_TRIG_SEL) and pwdata[7:6] != pwdata[5:4]) |=> !shared_high;
    endproperty
    a_remap_on_write: assert property (p_remap_on_write) else $error("map not split after write"); // R15
endmodule
`default_nettype wire

// [testbench/pulse_next_data_buffer_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module pulse_next_data_buffer_bench;
    import pndb_pkg::*;
    logic clk, resetn, psel, penable, pwrite, pready, pslverr, rerr;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, rdata;
    logic [3:0] pstrb, compare_match_a, compare_match_b, m_nov;
    logic [PAT_W-1:0] pattern_out, m_en, m_po;
    logic [7:0] m_sel, m_nh, m_nl;
    logic [7:0] addrs [9];
    int mismatches, comparisons;

    pndb_core u_pndb_core (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .compare_match_a(compare_match_a), .compare_match_b(compare_match_b),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pattern_out(pattern_out));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic report_and_stop;
        if (mismatches == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Expected {error, read data} from the bench's own copy of the registers
    function automatic logic [32:0] model_rd(input logic [7:0] a);
        logic sh_h;
        logic sh_l;
        sh_h = m_sel[7:6] == m_sel[5:4];
        sh_l = m_sel[3:2] == m_sel[1:0];
        case (a)
            ADDR_TRIG_SEL: return {25'h0, m_sel};
            ADDR_NON_OVERLAP: return {29'h0, m_nov};
            ADDR_ENABLE: return {17'h0, m_en};
            ADDR_OUT_PAT: return {17'h0, m_po};
            ADDR_NEXT_HIGH: return {25'h0, sh_h ? m_nh : {m_nh[7:4], 4'hF}};
            ADDR_NEXT_HIGH_LN: return sh_h ? {1'b1, 32'h0} : {25'h0, 4'hF, m_nh[3:0]};
            ADDR_NEXT_LOW: return {25'h0, sh_l ? m_nl : {m_nl[7:4], 4'hF}};
            ADDR_NEXT_LOW_LN: return sh_l ? {1'b1, 32'h0} : {25'h0, 4'hF, m_nl[3:0]};
            default: return {1'b1, 32'h0};
        endcase
    endfunction

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) mismatches++;
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        logic [32:0] e;
        e = model_rd(a);
        apb(1'b0, a, 32'h0);
        check(rdata, e[31:0]);
        check({31'h0, rerr}, {31'h0, e[32]});
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [32:0] e;
        logic sh;
        e = model_rd(a);
        sh = (a == ADDR_NEXT_HIGH) ? m_sel[7:6] == m_sel[5:4] : m_sel[3:2] == m_sel[1:0];
        apb(1'b1, a, d);
        check({31'h0, rerr}, {31'h0, e[32]});
        if (!e[32]) begin
            case (a)
                ADDR_TRIG_SEL: m_sel = d[7:0];
                ADDR_NON_OVERLAP: m_nov = d[3:0];
                ADDR_ENABLE: m_en = d[15:0];
                ADDR_OUT_PAT: m_po = (m_po & m_en) | (d[15:0] & ~m_en);
                ADDR_NEXT_HIGH: if (sh) m_nh = d[7:0]; else m_nh[7:4] = d[7:4];
                ADDR_NEXT_HIGH_LN: m_nh[3:0] = d[3:0];
                ADDR_NEXT_LOW: if (sh) m_nl = d[7:0]; else m_nl[7:4] = d[7:4];
                ADDR_NEXT_LOW_LN: m_nl[3:0] = d[3:0];
                default: ;
            endcase
        end
    endtask

    // One-cycle match pulses; output loads at the edge that samples them
    task automatic pulse(input logic [3:0] a, input logic [3:0] b);
        logic [15:0] nd;
        logic [1:0] ch;
        nd = {m_nh, m_nl};
        @(posedge clk);
        compare_match_a <= a;
        compare_match_b <= b;
        for (int i = 0; i < 16; i++) begin
            ch = m_sel[2*(i/4) +: 2];
            if (m_en[i] && (a[ch] || (m_nov[i/4] && b[ch]))) m_po[i] = nd[i];
        end
        @(posedge clk);
        compare_match_a <= 4'h0;
        compare_match_b <= 4'h0;
        // Loaded at the previous edge, stable through this one
        @(posedge clk);
        check({16'h0, pattern_out}, {16'h0, m_po});
    endtask

    task automatic model_reset;
        m_sel = TRIG_SEL_RST;
        m_nov = NON_OVERLAP_RST;
        m_en = ENABLE_RST;
        m_po = OUT_PAT_RST;
        m_nh = NEXT_RST;
        m_nl = NEXT_RST;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        report_and_stop();
    end

    initial begin
        logic [1:0] c;
        resetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'hF;
        compare_match_a = 4'h0;
        compare_match_b = 4'h0;
        mismatches = 0;
        comparisons = 0;
        model_reset();
        addrs = '{ADDR_TRIG_SEL, ADDR_NON_OVERLAP, ADDR_ENABLE, ADDR_OUT_PAT, ADDR_NEXT_HIGH,
            ADDR_NEXT_HIGH_LN, ADDR_NEXT_LOW, ADDR_NEXT_LOW_LN, 8'h40};
        void'($urandom(32'hb9754e69));
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        foreach (addrs[i]) rd(addrs[i]);
        wr(ADDR_ENABLE, $urandom);
        for (int k = 0; k < 4; k++) begin
            c = k[1:0];
            wr(ADDR_TRIG_SEL, {24'h0, {4{c}}});
            wr(ADDR_NEXT_HIGH, $urandom);
            wr(ADDR_NEXT_LOW, $urandom);
            pulse(4'h1 << (c + 2'd1), 4'h0);
            pulse(4'h0, 4'h1 << c);
            wr(ADDR_NON_OVERLAP, 32'hF);
            pulse(4'h0, 4'h1 << c);
            wr(ADDR_NON_OVERLAP, 32'h0);
            pulse(4'h1 << c, 4'h0);
        end
        // Split corner first, then random mix with both mappings
        wr(ADDR_TRIG_SEL, 32'h1B);
        for (int k = 0; k < 60; k++) begin
            if ($urandom % 4 == 0) wr(ADDR_TRIG_SEL, $urandom);
            wr(addrs[$urandom % 9], $urandom);
            rd(addrs[$urandom % 9]);
            if ($urandom % 2 == 0) pulse(4'($urandom), 4'($urandom));
        end
        // Reset in mid-run must return everything written above to its reset value
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        model_reset();
        foreach (addrs[i]) rd(addrs[i]);
        pulse(4'hF, 4'hF);
        foreach (addrs[i]) rd(addrs[i]);
        report_and_stop();
    end
endmodule
`default_nettype wire
